// ===== core/aux_unit.sv
`timescale 1ns/1ns
module aux_unit #(
  parameter int NREG = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic upd,
  input wire seq_pkg::ind_mode_t imode,
  input wire logic new_sel_en,
  input wire logic [2:0] new_sel,
  input wire logic ld_en,
  input wire logic [2:0] ld_idx,
  input wire logic [15:0] ld_val,
  // Results
  output logic [15:0] cur_addr,
  output logic [2:0] sel_out
);
  initial begin
    if (NREG != 8) $error("aux_unit needs exactly eight registers");
  end

  logic [15:0] aux_regs_r [NREG];
  logic [15:0] aux_regs_nxt [NREG];
  logic [2:0] aux_reg_select_r;
  logic [2:0] aux_reg_select_nxt;
  logic [15:0] cur;
  logic [15:0] idx;

  function automatic logic [15:0] brev(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  assign cur = aux_regs_r[aux_reg_select_r];
  assign idx = aux_regs_r[0];
  assign cur_addr = cur;
  assign sel_out = aux_reg_select_r;

  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      aux_regs_nxt[i] = aux_regs_r[i];
    end
    aux_reg_select_nxt = aux_reg_select_r;
    if (ld_en) begin
      aux_regs_nxt[ld_idx] = ld_val;
    end
    if (upd) begin
      // Modify current register in the using cycle, then switch selector
      case (imode)
        seq_pkg::IND_INC: aux_regs_nxt[aux_reg_select_r] = cur + 16'h0001;
        seq_pkg::IND_DEC: aux_regs_nxt[aux_reg_select_r] = cur - 16'h0001;
        seq_pkg::IND_ADD0: aux_regs_nxt[aux_reg_select_r] = cur + idx;
        seq_pkg::IND_SUB0: aux_regs_nxt[aux_reg_select_r] = cur - idx;
        // Reverse-carry add for FFT addressing
        seq_pkg::IND_BRADD: aux_regs_nxt[aux_reg_select_r] = brev(brev(cur) + brev(idx));
        seq_pkg::IND_BRSUB: aux_regs_nxt[aux_reg_select_r] = brev(brev(cur) - brev(idx));
        default: aux_regs_nxt[aux_reg_select_r] = cur;
      endcase
      if (new_sel_en) begin
        aux_reg_select_nxt = new_sel;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < NREG; i++) begin
        aux_regs_r[i] <= 16'h0000;
      end
      aux_reg_select_r <= seq_pkg::ARSEL_RESET;
    end else begin
      aux_regs_r <= aux_regs_nxt;
      aux_reg_select_r <= aux_reg_select_nxt;
    end
  end

  chk_sel_after_update: assert property (@(posedge mclk) disable iff (rst)
    upd && new_sel_en |=> sel_out == $past(new_sel))
    else $error("selector not loaded after update");
endmodule

// ===== core/dsp_core_sequencer_bus_ctl.sv
// Function
// - Three active-low external user interrupt inputs
// - Serial, timer and trap raise internal interrupts
// - Reset highest, serial transmit lowest priority
// - Vectors aligned on two-word boundaries
// - Interrupts wait for multicycle instruction end
// - Deferral covers ready-stretched cycles and repeats, except just before the last execution
// - I/O uses the same external bus cycle
// - Wait while ready low, then resume
// - Eight-bit register sizes global data space
// - Request bus for operands inside global space
// - Ready sets global memory cycle length
// - Takeover request floats bus, acknowledges
// - Direct address: page pointer above seven bits
// - Three-bit selector picks one of eight
// - Seven indirect modification variants
// - Update register first, then load selector
// - Immediate operand comes from instruction
// - Repeat next instruction up to 256 times
// - Counter holds executions minus one
// - Repeated multicycle ops take one cycle each
`timescale 1ns/1ns
module dsp_core_sequencer_bus_ctl #(
  parameter int GSS_W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_pin_n,
  // Interrupt sources
  input wire logic [2:0] ext_irq_n,
  input wire logic serial_rx_irq,
  input wire logic serial_tx_irq,
  input wire logic timer_irq,
  input wire logic [7:0] irq_enable,
  // Instruction from decoder
  input wire seq_pkg::instr_t instr,
  output logic instr_ready,
  // Interrupt dispatch
  output logic irq_take,
  output logic [15:0] irq_vector,
  input wire logic irq_ack,
  // Operand results
  output logic [15:0] operand,
  output logic [15:0] data_addr,
  output logic [7:0] repeat_counter,
  output logic [2:0] aux_reg_select,
  output logic [7:0] global_space_size,
  // External bus
  output seq_pkg::ext_bus_t bus_out,
  output logic bus_oe,
  input wire logic [15:0] ext_rdata,
  input wire logic ready,
  output logic global_bus_req_n,
  input wire logic takeover_req_n,
  output logic takeover_ack_n,
  // Auxiliary register loads
  input wire logic aux_ld_en,
  input wire logic [2:0] aux_ld_idx,
  input wire logic [15:0] aux_ld_val
);
  initial begin
    if (GSS_W != 8) $error("global space size register must be eight bits");
  end

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_HOLD = 4'b1000
  } st_t;

  st_t st_r, st_nxt;
  logic [1:0] cyc_r, cyc_nxt;
  logic [7:0] rpt_r, rpt_nxt;
  logic rpt_act_r, rpt_act_nxt;
  logic [8:0] page_r, page_nxt;
  logic [7:0] gss_r, gss_nxt;
  logic [7:0] pend_r, pend_nxt;
  logic [15:0] opnd_r, opnd_nxt;
  logic [15:0] addr_r, addr_nxt;
  seq_pkg::ext_bus_t bus_r, bus_nxt;
  logic greq_r, greq_nxt;

  logic [15:0] ind_addr;
  logic [15:0] eff_addr;
  logic in_global;
  logic ext_cycle;
  logic done;
  logic boundary;
  logic irq_any;
  logic [2:0] irq_win;
  logic [7:0] raw;
  logic bus_live;
  logic rpt_busy;

  // Data address: direct or through the selected auxiliary register
  assign eff_addr = (instr.amode == seq_pkg::ADR_DIRECT) ?
    {page_r, instr.dfield} : ind_addr;
  // Global space occupies the top of data memory, sized in 256-word pages
  assign in_global = instr.mem_access && !instr.io_space &&
    (instr.amode != seq_pkg::ADR_IMMEDIATE) && (gss_r != 8'h00) &&
    (eff_addr[15:8] >= ~gss_r + 8'h01);
  assign ext_cycle = instr.mem_access && (instr.amode != seq_pkg::ADR_IMMEDIATE) &&
    (eff_addr != seq_pkg::GSS_ADDR);
  // Strobes must be on the pins before ready may close the access
  assign bus_live = !bus_r.rd_n || !bus_r.wr_n;

  // Multicycle instructions end on their last cycle; repeats collapse to one
  assign done = (st_r == ST_EXEC) && instr.valid &&
    (rpt_act_r || cyc_r >= instr.cycles) && (!ext_cycle || (ready && bus_live));
  // Interrupts only between instructions; a repeat run blocks them only while its counter is nonzero
  assign rpt_busy = rpt_act_r && rpt_r != 8'h00;
  assign boundary = (st_r == ST_IDLE || done) && !rpt_busy;
  assign instr_ready = done;

  aux_unit #(.NREG(8)) u_aux (
    .mclk(mclk),
    .rst(rst),
    .upd(done && instr.amode == seq_pkg::ADR_INDIRECT),
    .imode(instr.imode),
    .new_sel_en(instr.new_sel_en),
    .new_sel(instr.new_sel),
    .ld_en(aux_ld_en),
    .ld_idx(aux_ld_idx),
    .ld_val(aux_ld_val),
    .cur_addr(ind_addr),
    .sel_out(aux_reg_select)
  );

  assign raw = {serial_tx_irq, serial_rx_irq, timer_irq, instr.valid && instr.trap,
    ~ext_irq_n[2], ~ext_irq_n[1], ~ext_irq_n[0], ~reset_pin_n};

  irq_prio #(.N(8)) u_prio (
    .pend(pend_r),
    .any(irq_any),
    .win(irq_win)
  );

  assign irq_take = irq_any && boundary && st_r != ST_HOLD;
  assign irq_vector = seq_pkg::VEC_BASE + (16'(irq_win) << seq_pkg::VEC_SHIFT);

  always_comb begin
    st_nxt = st_r;
    cyc_nxt = cyc_r;
    rpt_nxt = rpt_r;
    rpt_act_nxt = rpt_act_r;
    page_nxt = page_r;
    gss_nxt = gss_r;
    opnd_nxt = opnd_r;
    addr_nxt = addr_r;
    bus_nxt = bus_r;
    greq_nxt = 1'b0;
    // Sources latch until acknowledged; a new event beats the clear
    pend_nxt = pend_r;
    if (irq_take && irq_ack) begin
      pend_nxt[irq_win] = 1'b0;
    end
    pend_nxt = pend_nxt | (raw & (irq_enable | 8'h01));
    case (st_r)
      ST_IDLE: begin
        if (!takeover_req_n) begin
          st_nxt = ST_HOLD;
        end else if (instr.valid) begin
          st_nxt = ST_EXEC;
          cyc_nxt = 2'h0;
        end
      end
      ST_EXEC: begin
        addr_nxt = eff_addr;
        if (ext_cycle) begin
          // I/O and memory share one cycle form, told apart by io_n
          bus_nxt.addr = eff_addr;
          bus_nxt.wdata = opnd_r;
          bus_nxt.rd_n = instr.wr;
          bus_nxt.wr_n = !instr.wr;
          bus_nxt.io_n = !instr.io_space;
          greq_nxt = in_global;
        end
        if (ext_cycle && !(ready && bus_live)) begin
          st_nxt = ST_WAIT;
        end else if (done) begin
          cyc_nxt = 2'h0;
          // Drop the strobes so the next access starts a fresh handshake
          bus_nxt.rd_n = 1'b1;
          bus_nxt.wr_n = 1'b1;
          bus_nxt.io_n = 1'b1;
          if (instr.amode == seq_pkg::ADR_IMMEDIATE) begin
            opnd_nxt = instr.imm;
          end else if (ext_cycle && !instr.wr) begin
            opnd_nxt = ext_rdata;
          end
          if (instr.ld_page) begin
            page_nxt = instr.imm[8:0];
          end
          if (!instr.wr && instr.mem_access && eff_addr == seq_pkg::GSS_ADDR) begin
            opnd_nxt = {8'h00, gss_r};
          end else if (instr.wr && eff_addr == seq_pkg::GSS_ADDR) begin
            gss_nxt = opnd_r[7:0];
          end
          if (instr.ld_rpt_imm) begin
            rpt_nxt = instr.imm[7:0];
            rpt_act_nxt = 1'b0;
          end else if (instr.ld_rpt_mem) begin
            rpt_nxt = ext_rdata[7:0];
            rpt_act_nxt = 1'b0;
          end else if (rpt_act_r && rpt_r != 8'h00) begin
            rpt_nxt = rpt_r - 8'h01;
          end else begin
            rpt_act_nxt = 1'b0;
          end
          if (instr.ld_rpt_imm || instr.ld_rpt_mem) begin
            rpt_act_nxt = 1'b1;
          end
          st_nxt = (!takeover_req_n) ? ST_HOLD : ST_IDLE;
        end else begin
          cyc_nxt = cyc_r + 2'h1;
        end
      end
      ST_WAIT: begin
        greq_nxt = greq_r;
        if (ready) begin
          st_nxt = ST_EXEC;
          cyc_nxt = instr.cycles;
        end
      end
      ST_HOLD: begin
        if (takeover_req_n) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      cyc_r <= 2'h0;
      rpt_r <= seq_pkg::RPT_RESET;
      rpt_act_r <= 1'b0;
      page_r <= seq_pkg::PAGE_RESET;
      gss_r <= seq_pkg::GSS_RESET;
      pend_r <= 8'h00;
      opnd_r <= 16'h0000;
      addr_r <= 16'h0000;
      bus_r <= '{addr: 16'h0000, wdata: 16'h0000, rd_n: 1'b1, wr_n: 1'b1, io_n: 1'b1};
      greq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cyc_r <= cyc_nxt;
      rpt_r <= rpt_nxt;
      rpt_act_r <= rpt_act_nxt;
      page_r <= page_nxt;
      gss_r <= gss_nxt;
      pend_r <= pend_nxt;
      opnd_r <= opnd_nxt;
      addr_r <= addr_nxt;
      bus_r <= bus_nxt;
      greq_r <= greq_nxt;
    end
  end

  assign operand = opnd_r;
  assign data_addr = addr_r;
  assign repeat_counter = rpt_r;
  assign global_space_size = gss_r;
  assign bus_out = bus_r;
  assign bus_oe = st_r != ST_HOLD;
  assign takeover_ack_n = st_r != ST_HOLD;
  assign global_bus_req_n = !greq_r;

  chk_hold_floats: assert property (@(posedge mclk) disable iff (rst)
    !takeover_ack_n |-> !bus_oe)
    else $error("bus driven during takeover");
  chk_irq_deferred: assert property (@(posedge mclk) disable iff (rst)
    st_r == ST_WAIT |-> !irq_take)
    else $error("interrupt taken mid instruction");
  chk_wait_ready: assert property (@(posedge mclk) disable iff (rst)
    st_r == ST_WAIT && !ready |=> st_r == ST_WAIT)
    else $error("left wait without ready");
  chk_vec_align: assert property (@(posedge mclk) disable iff (rst)
    irq_take |-> irq_vector[0] == 1'b0)
    else $error("vector not two-word aligned");
  chk_reset_first: assert property (@(posedge mclk) disable iff (rst)
    irq_take && pend_r[0] |-> irq_win == seq_pkg::SRC_RESET)
    else $error("reset not highest priority");
  chk_breq_global: assert property (@(posedge mclk) disable iff (rst)
    !global_bus_req_n |-> $past(st_r == ST_WAIT || (in_global && st_r == ST_EXEC)))
    else $error("bus request outside global space");
  chk_rpt_load: assert property (@(posedge mclk) disable iff (rst)
    done && instr.ld_rpt_imm |=> repeat_counter == $past(instr.imm[7:0]) && rpt_act_r)
    else $error("repeat counter not loaded");
  chk_direct_addr: assert property (@(posedge mclk) disable iff (rst)
    st_r == ST_EXEC && instr.amode == seq_pkg::ADR_DIRECT |=>
    data_addr == {$past(page_r), $past(instr.dfield)})
    else $error("direct address wrong");
  chk_rpt_no_irq: assert property (@(posedge mclk) disable iff (rst)
    rpt_busy |-> !irq_take)
    else $error("interrupt taken inside repeat");
  chk_bus_release: assert property (@(posedge mclk) disable iff (rst)
    done && ext_cycle |=> bus_out.rd_n && bus_out.wr_n)
    else $error("bus strobes held after access");
endmodule

// ===== core/irq_prio.sv
`timescale 1ns/1ns
module irq_prio #(
  parameter int N = 8
) (
  // Pending sources
  input wire logic [N-1:0] pend,
  // Winner
  output logic any,
  output logic [2:0] win
);
  initial begin
    if (N != 8) $error("irq_prio serves eight sources");
  end

  // Lowest index wins: reset first, serial transmit last
  always_comb begin
    any = |pend;
    win = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        win = 3'(i);
      end
    end
  end
endmodule

// ===== core/seq_pkg.sv
package seq_pkg;
  // Interrupt source indices, ascending number = lower priority
  localparam int IRQ_NUM = 8;
  localparam logic [2:0] SRC_RESET = 3'h0;
  localparam logic [2:0] SRC_EXT0 = 3'h1;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [2:0] SRC_EXT2 = 3'h3;
  localparam logic [2:0] SRC_TRAP = 3'h4;
  localparam logic [2:0] SRC_TIMER = 3'h5;
  localparam logic [2:0] SRC_RX = 3'h6;
  localparam logic [2:0] SRC_TX = 3'h7;
  // Vectors sit on two-word boundaries
  localparam logic [15:0] VEC_BASE = 16'h0000;
  localparam int VEC_SHIFT = 1;
  // Address of the memory-mapped global space size register
  localparam logic [15:0] GSS_ADDR = 16'h0005;
  localparam logic [7:0] GSS_RESET = 8'h00;
  localparam logic [8:0] PAGE_RESET = 9'h000;
  localparam logic [2:0] ARSEL_RESET = 3'h0;
  localparam logic [7:0] RPT_RESET = 8'h00;
  localparam int DIRECT_BITS = 7;

  typedef enum logic [2:0] {
    IND_NONE = 3'h0,
    IND_INC = 3'h1,
    IND_DEC = 3'h2,
    IND_ADD0 = 3'h3,
    IND_SUB0 = 3'h4,
    IND_BRADD = 3'h5,
    IND_BRSUB = 3'h6
  } ind_mode_t;

  typedef enum logic [1:0] {
    ADR_DIRECT = 2'h0,
    ADR_INDIRECT = 2'h1,
    ADR_IMMEDIATE = 2'h2
  } adr_mode_t;

  // One decoded instruction as presented by the decoder
  typedef struct packed {
    logic valid;
    adr_mode_t amode;
    logic [6:0] dfield;
    ind_mode_t imode;
    logic new_sel_en;
    logic [2:0] new_sel;
    logic [15:0] imm;
    logic mem_access;
    logic io_space;
    logic wr;
    logic [1:0] cycles;
    logic ld_page;
    logic ld_rpt_mem;
    logic ld_rpt_imm;
    logic trap;
  } instr_t;

  // External bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic rd_n;
    logic wr_n;
    logic io_n;
  } ext_bus_t;
endpackage

// ===== verification/ext_mem_model.sv
`timescale 1ns/1ns
module ext_mem_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus from the core
  input wire seq_pkg::ext_bus_t bus_out,
  input wire logic bus_oe,
  input wire logic [3:0] wait_n,
  // Answer to the core
  output logic [15:0] ext_rdata,
  output logic ready
);
  logic [3:0] cnt_r;
  logic [15:0] last_r;
  logic act;
  assign act = bus_oe && (!bus_out.rd_n || !bus_out.wr_n);
  // Slow or shared device: ready stays low until the access is granted and done
  assign ready = act && (cnt_r == wait_n);
  // Released lines show the inverse of the last word so a stale value never matches
  assign ext_rdata = act ? (bus_out.addr ^ 16'h5A5A) : ~last_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r <= 4'h0;
      last_r <= 16'h0000;
    end else begin
      // Ready holds once reached until the core drops its strobes
      if (!act) begin
        cnt_r <= 4'h0;
      end else if (cnt_r != wait_n) begin
        cnt_r <= cnt_r + 4'h1;
      end
      if (act) begin
        last_r <= ext_rdata;
      end
    end
  end
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic mclk, rst, reset_pin_n, serial_rx_irq, serial_tx_irq, timer_irq, irq_ack;
  logic [2:0] ext_irq_n, aux_reg_select, aux_ld_idx;
  logic [7:0] irq_enable, repeat_counter, global_space_size;
  seq_pkg::instr_t instr;
  seq_pkg::ext_bus_t bus_out;
  logic instr_ready, irq_take, bus_oe, ready, global_bus_req_n;
  logic takeover_req_n, takeover_ack_n, aux_ld_en, busy, greq_seen, early_irq;
  logic [15:0] irq_vector, operand, data_addr, ext_rdata, aux_ld_val, io_addr;
  logic [3:0] wait_n;
  int n_fail, cmp_count, cyc;

  dsp_core_sequencer_bus_ctl #(.GSS_W(8)) u_dut (
    .mclk, .rst, .reset_pin_n, .ext_irq_n, .serial_rx_irq, .serial_tx_irq, .timer_irq,
    .irq_enable, .instr, .instr_ready, .irq_take, .irq_vector, .irq_ack, .operand,
    .data_addr, .repeat_counter, .aux_reg_select, .global_space_size, .bus_out, .bus_oe,
    .ext_rdata, .ready, .global_bus_req_n, .takeover_req_n, .takeover_ack_n,
    .aux_ld_en, .aux_ld_idx, .aux_ld_val);
  ext_mem_model u_mem (.mclk, .rst, .bus_out, .bus_oe, .wait_n, .ext_rdata, .ready);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(negedge mclk) begin
    if (busy && irq_take && !instr_ready) early_irq = 1'b1;
    if (!global_bus_req_n) greq_seen = 1'b1;
    if (!bus_out.io_n && !bus_out.rd_n) io_addr = bus_out.addr;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic seq_pkg::instr_t blank();
    blank = '0;
    blank.valid = 1'b1;
  endfunction

  task automatic run(input seq_pkg::instr_t i);
    greq_seen = 1'b0;
    @(posedge mclk);
    instr <= i;
    busy = 1'b1;
    cyc = 0;
    do begin
      @(negedge mclk);
      cyc++;
    end while (!instr_ready && cyc < 100);
    chk("instr_ready", 16'h1, {15'h0, instr_ready});
    @(posedge mclk);
    instr <= '0;
    busy = 1'b0;
    @(negedge mclk);
  endtask

  task automatic take(input logic [2:0] src);
    chk("irq_take", 16'h1, {15'h0, irq_take});
    chk("irq_vector", seq_pkg::VEC_BASE + ({13'h0, src} << seq_pkg::VEC_SHIFT), irq_vector);
    @(posedge mclk);
    irq_ack <= 1'b1;
    @(posedge mclk);
    irq_ack <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic rd(input logic [8:0] page, input logic [6:0] d, input logic [3:0] w);
    seq_pkg::instr_t i;
    i = blank();
    i.ld_page = 1'b1;
    i.imm = {7'h00, page};
    run(i);
    i = blank();
    i.mem_access = 1'b1;
    i.dfield = d;
    wait_n = w;
    run(i);
  endtask

  task automatic t_direct();
    seq_pkg::instr_t i;
    rd(9'h123, 7'h45, 4'h0);
    chk("data_addr", {9'h123, 7'h45}, data_addr);
    chk("operand", {9'h123, 7'h45} ^ 16'h5A5A, operand);
    chk("greq_outside", 16'h0, {15'h0, greq_seen});
    i = blank();
    i.mem_access = 1'b1;
    i.io_space = 1'b1;
    i.dfield = 7'h11;
    run(i);
    chk("io_addr", {9'h123, 7'h11}, io_addr);
    chk("io_operand", {9'h123, 7'h11} ^ 16'h5A5A, operand);
    chk("greq_io", 16'h0, {15'h0, greq_seen});
    i = blank();
    i.amode = seq_pkg::ADR_IMMEDIATE;
    i.imm = 16'hBEEF;
    run(i);
    chk("imm_operand", 16'hBEEF, operand);
    $display("test direct io immediate done");
  endtask

  task automatic t_indirect();
    seq_pkg::instr_t i;
    seq_pkg::ind_mode_t m[8] = '{seq_pkg::IND_INC, seq_pkg::IND_DEC, seq_pkg::IND_ADD0,
      seq_pkg::IND_SUB0, seq_pkg::IND_BRADD, seq_pkg::IND_BRADD, seq_pkg::IND_BRSUB,
      seq_pkg::IND_NONE};
    // Second reversed add carries downward: 0x210 plus 0x10 lands on 0x208
    logic [15:0] dl[8] = '{16'h0001, 16'hFFFF, 16'h0010, 16'hFFF0, 16'h0010, 16'hFFF8, 16'h0008,
      16'h0000};
    logic [15:0] cur;
    logic [2:0] idx[3] = '{3'h0, 3'h3, 3'h5};
    logic [15:0] val[3] = '{16'h0010, 16'h0200, 16'h0300};
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      aux_ld_en <= 1'b1;
      aux_ld_idx <= idx[k];
      aux_ld_val <= val[k];
    end
    @(posedge mclk);
    aux_ld_en <= 1'b0;
    i = blank();
    i.amode = seq_pkg::ADR_INDIRECT;
    i.mem_access = 1'b1;
    i.new_sel_en = 1'b1;
    i.new_sel = 3'h3;
    run(i);
    chk("aux_sel", 16'h3, {13'h0, aux_reg_select});
    i.new_sel_en = 1'b0;
    cur = 16'h0200;
    for (int k = 0; k < 8; k++) begin
      i.imode = m[k];
      run(i);
      chk("ind_addr", cur, data_addr);
      cur = cur + dl[k];
    end
    i.imode = seq_pkg::IND_INC;
    i.new_sel_en = 1'b1;
    i.new_sel = 3'h5;
    run(i);
    chk("upd_before_sel", cur, data_addr);
    i.imode = seq_pkg::IND_NONE;
    i.new_sel = 3'h3;
    run(i);
    chk("new_sel_addr", 16'h0300, data_addr);
    run(i);
    chk("old_reg_incr", cur + 16'h0001, data_addr);
    $display("test indirect done");
  endtask

  task automatic t_repeat_global();
    seq_pkg::instr_t i;
    i = blank();
    i.ld_rpt_imm = 1'b1;
    i.imm = 16'h00FF;
    run(i);
    chk("rpt_imm", 16'h00FF, {8'h0, repeat_counter});
    rd(9'h123, 7'h00, 4'h1);
    i = blank();
    i.ld_rpt_mem = 1'b1;
    i.mem_access = 1'b1;
    run(i);
    chk("rpt_mem", 16'h00DA, {8'h0, repeat_counter});
    rd(9'h000, 7'h00, 4'h0);
    i = blank();
    i.amode = seq_pkg::ADR_IMMEDIATE;
    i.imm = 16'h0001;
    run(i);
    i = blank();
    i.mem_access = 1'b1;
    i.wr = 1'b1;
    i.dfield = seq_pkg::GSS_ADDR[6:0];
    i.imm = 16'h0001;
    run(i);
    chk("gss", 16'h0001, {8'h0, global_space_size});
    rd(9'h1FF, 7'h10, 4'h3);
    chk("greq_inside", 16'h1, {15'h0, greq_seen});
    rd(9'h1FD, 7'h10, 4'h0);
    chk("greq_below", 16'h0, {15'h0, greq_seen});
    i = blank();
    i.ld_rpt_imm = 1'b1;
    i.imm = 16'h0002;
    run(i);
    i = blank();
    i.cycles = 2'h3;
    run(i);
    chk("rpt_single", 16'h0002, 16'(cyc));
    run(i);
    chk("rpt_count", 16'h0000, {8'h0, repeat_counter});
    $display("test repeat global done");
  endtask

  task automatic t_irq();
    seq_pkg::instr_t i;
    i = blank();
    i.mem_access = 1'b1;
    wait_n = 4'h5;
    early_irq = 1'b0;
    fork
      run(i);
      begin
        repeat (3) @(posedge mclk);
        ext_irq_n <= 3'b101;
        timer_irq <= 1'b1;
        @(posedge mclk);
        ext_irq_n <= 3'b111;
        timer_irq <= 1'b0;
      end
    join
    chk("wait_len", 16'h1, {15'h0, cyc > 5});
    chk("deferred", 16'h0, {15'h0, early_irq});
    take(seq_pkg::SRC_EXT1);
    take(seq_pkg::SRC_TIMER);
    for (int k = 0; k < 3; k += 2) begin
      @(posedge mclk);
      ext_irq_n <= ~(3'b001 << k);
      @(posedge mclk);
      ext_irq_n <= 3'b111;
      @(negedge mclk);
      take(seq_pkg::SRC_EXT0 + 3'(k));
    end
    @(posedge mclk);
    {reset_pin_n, serial_rx_irq, serial_tx_irq} <= 3'b011;
    @(posedge mclk);
    {reset_pin_n, serial_rx_irq, serial_tx_irq} <= 3'b100;
    @(negedge mclk);
    take(seq_pkg::SRC_RESET);
    take(seq_pkg::SRC_RX);
    take(seq_pkg::SRC_TX);
    i.mem_access = 1'b0;
    i.trap = 1'b1;
    run(i);
    take(seq_pkg::SRC_TRAP);
    @(posedge mclk);
    irq_enable <= 8'hDF;
    timer_irq <= 1'b1;
    @(posedge mclk);
    timer_irq <= 1'b0;
    irq_enable <= 8'hFF;
    @(negedge mclk);
    chk("masked", 16'h0, {15'h0, irq_take});
    $display("test interrupts done");
  endtask

  task automatic t_takeover();
    @(posedge mclk);
    takeover_req_n <= 1'b0;
    repeat (6) @(negedge mclk);
    chk("hold_ack", 16'h0, {15'h0, takeover_ack_n});
    chk("hold_float", 16'h0, {15'h0, bus_oe});
    @(posedge mclk);
    takeover_req_n <= 1'b1;
    repeat (6) @(negedge mclk);
    chk("hold_done", 16'h1, {15'h0, takeover_ack_n});
    $display("test takeover done");
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(8 * 20000);
    n_fail++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    {rst, reset_pin_n, serial_rx_irq, serial_tx_irq, timer_irq, irq_ack} = 6'b110000;
    {takeover_req_n, aux_ld_en, busy, greq_seen, early_irq} = 5'b10000;
    ext_irq_n = 3'b111;
    irq_enable = 8'hFF;
    instr = '0;
    aux_ld_idx = 3'h0;
    aux_ld_val = 16'h0000;
    wait_n = 4'h0;
    io_addr = 16'h0000;
    n_fail = 0;
    cmp_count = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk("rst_gss", 16'h0, {8'h0, global_space_size});
    chk("rst_greq", 16'h1, {15'h0, global_bus_req_n});
    t_direct();
    t_indirect();
    t_repeat_global();
    t_irq();
    t_takeover();
    end_sim();
  end
endmodule
